// [common/sadc_pkg.sv]
// constants shared by the converter sequencer and its approximation core
package sadc_pkg;
    // ==========================================
    // timing: the main oscillator is the block clock
    localparam int CLK_PERIOD_NS  = 20;
    localparam int OSC_PERIOD_NS  = 20;
    localparam int START_WAIT_OSC = 16;
    localparam int START_WAIT_NS  = START_WAIT_OSC * OSC_PERIOD_NS;
    // longest time, rounds down
    localparam int START_WAIT_CYC = START_WAIT_NS / CLK_PERIOD_NS;
    localparam int CONV_OSC       = 168;
    localparam int CONV_NS        = CONV_OSC * OSC_PERIOD_NS;
    localparam int CONV_CYC       = CONV_NS / CLK_PERIOD_NS;
    localparam int ADC_BITS       = 8;
    localparam int SAMPLE_CYC     = 8;
    localparam int BIT_CYC        = (CONV_CYC - SAMPLE_CYC) / ADC_BITS;
    localparam logic [3:0] PRESC_LAST = 4'(START_WAIT_CYC - 1);

    // ==========================================
    // register byte offsets
    localparam logic [7:0] MODE_OFS     = 8'h00;
    localparam logic [7:0] RESULT_OFS   = 8'h04;
    localparam logic [7:0] CLKCTL_OFS   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
    localparam logic [7:0] MODE_SET_OFS = 8'h14;
    localparam logic [7:0] MODE_CLR_OFS = 8'h18;

    // ==========================================
    // field positions
    localparam int CHAN_LSB     = 4;
    localparam int CHAN_MSB     = 6;
    localparam int START_BIT    = 3;
    localparam int DONE_BIT     = 2;
    localparam int CLK_STOP_BIT = 0;
    localparam int SUBCLK_BIT   = 1;
    localparam int DIV_LSB      = 2;
    localparam int DIV_MSB      = 3;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_RESTART  = 1;

    // ==========================================
    // values after reset
    localparam logic [7:0] MODE_RST     = 8'h04;
    localparam logic [7:0] RESULT_RST   = 8'h7F;
    localparam logic [3:0] CLKCTL_RST   = 4'h0;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    typedef enum logic [1:0] {CS_IDLE, CS_SAMPLE, CS_DECIDE} sadc_core_state_e;
endpackage

// [hdl/sadc_sar_core.sv]
// binary search engine: sample phase, then one bit decision per slot
`timescale 1ns/1ns
`default_nettype none
module sadc_sar_core #(
    parameter int W       = 8,
    parameter int SAMPLES = 8,
    parameter int BITSLOT = 20
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // control
    input  wire logic         step,
    input  wire logic         begin_i,
    input  wire logic         cmpAbove,
    // status and analog side
    output var  logic         busy,
    output var  logic         sampleHold,
    output var  logic [W-1:0] dacCode,
    output var  logic [W-1:0] result,
    output var  logic         donePulse
);
    sadc_pkg::sadc_core_state_e state;
    logic [7:0]   cnt;
    logic [W-1:0] trial;
    wire          slotEnd = (cnt == 8'(BITSLOT - 1));
    wire          sampEnd = (cnt == 8'(SAMPLES - 1));
    // comparator says input is at or above the trial code: keep the bit
    wire  [W-1:0] kept    = cmpAbove ? dacCode : (dacCode & ~trial);

    // ==========================================
    // search sequencer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state      <= sadc_pkg::CS_IDLE;
            cnt        <= 8'h00;
            trial      <= '0;
            dacCode    <= '0;
            result     <= '0;
            sampleHold <= 1'b0;
            donePulse  <= 1'b0;
        end else if (step) begin
            donePulse <= 1'b0;
            if (begin_i) begin
                // restart drops whatever was in progress
                state      <= sadc_pkg::CS_SAMPLE;
                cnt        <= 8'h00;
                sampleHold <= 1'b1;
                dacCode    <= '0;
            end else begin
                unique case (state)
                    sadc_pkg::CS_IDLE: begin
                        cnt <= 8'h00;
                    end
                    sadc_pkg::CS_SAMPLE: begin
                        cnt <= sampEnd ? 8'h00 : cnt + 8'h01;
                        if (sampEnd) begin
                            sampleHold <= 1'b0;
                            state      <= sadc_pkg::CS_DECIDE;
                            trial      <= {1'b1, {(W-1){1'b0}}};
                            dacCode    <= {1'b1, {(W-1){1'b0}}};
                        end
                    end
                    sadc_pkg::CS_DECIDE: begin
                        cnt <= slotEnd ? 8'h00 : cnt + 8'h01;
                        if (slotEnd) begin
                            trial <= trial >> 1;
                            if (trial[0]) begin
                                result    <= kept;
                                dacCode   <= kept;
                                donePulse <= 1'b1;
                                state     <= sadc_pkg::CS_IDLE;
                            end else begin
                                dacCode <= kept | (trial >> 1);
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign busy = (state != sadc_pkg::CS_IDLE);
endmodule
`default_nettype wire

// [hdl/sadc_sequencer.sv]
// converter sequencer: register file on APB, start timing, clock gating, result capture
//
// Functional notes
// - channel number comes from mode bits 6 to 4.
// - writing one to mode bit 3 starts a conversion; hardware then clears it.
// - at completion the result loads and mode bit 2 sets.
// - mode register resets to 04H: done flag one, rest zero.
// - mode written whole; done and start bits also set or cleared singly.
// - conversion begins within sixteen oscillator periods of the start bit.
// - done flag clears within sixteen periods of a start; software waits first.
// - one conversion takes 168 oscillator periods while the main clock runs.
// - result register reads 8 bits, ignores writes, resets to 7FH.
// - result built by binary search, one bit decision at a time.
// - eight inputs share one converter; one input per start.
// - selected input held at conversion start for the whole conversion.
// - converter stops while main clock stopped or subsystem clock halted.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module sadc_sequencer #(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              clkEn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // processor halt state, same clock domain
    input  wire logic              cpuHalt,
    // analog front end
    input  wire logic              cmpAbove,
    output var  logic [2:0]        analogInputSel,
    output var  logic              sampleHold,
    output var  logic [7:0]        dacCode,
    // interrupt
    output var  logic              irq
);
    // ==========================================
    // state
    logic [2:0] chanSel;
    logic       startBit;
    logic       doneFlag;
    logic [7:0] result;
    logic [3:0] clkCtl;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic [3:0] presc;
    logic       cmpMeta;
    logic       cmpSync;
    logic       coreBusy;
    logic       coreHold;
    logic [7:0] coreDac;
    logic [7:0] coreResult;
    logic       coreDone;

    // ==========================================
    // apb decode
    wire [7:0] addrLo    = 8'(paddr);
    wire       setupPh   = psel & ~penable;
    wire       wrAcc     = psel & penable & pready & pwrite & clkEn;
    wire       hitMode   = (addrLo == sadc_pkg::MODE_OFS);
    wire       hitResult = (addrLo == sadc_pkg::RESULT_OFS);
    wire       hitClk    = (addrLo == sadc_pkg::CLKCTL_OFS);
    wire       hitStat   = (addrLo == sadc_pkg::IRQ_STAT_OFS);
    wire       hitMask   = (addrLo == sadc_pkg::IRQ_MASK_OFS);
    wire       hitSet    = (addrLo == sadc_pkg::MODE_SET_OFS);
    wire       hitClr    = (addrLo == sadc_pkg::MODE_CLR_OFS);
    wire       addrHit   = hitMode | hitResult | hitClk | hitStat
                         | hitMask | hitSet | hitClr;
    wire       modeWr    = wrAcc & hitMode;
    wire       setWr     = wrAcc & hitSet;
    wire       clrWr     = wrAcc & hitClr;
    wire       wDone     = pwdata[sadc_pkg::DONE_BIT];
    wire       wStart    = pwdata[sadc_pkg::START_BIT];

    wire [7:0] modeRead  = {1'b0, chanSel, startBit, doneFlag, 2'b00};
    wire [7:0] readByte  = (hitMode | hitSet | hitClr) ? modeRead
                         : hitResult ? result
                         : hitClk    ? {4'h0, clkCtl}
                         : hitStat   ? {6'h00, irqStat}
                         : hitMask   ? {6'h00, irqMask}
                         : 8'h00;

    // ==========================================
    // run gating: converter runs only from a live main clock
    wire clkStop = clkCtl[sadc_pkg::CLK_STOP_BIT];
    wire subClk  = clkCtl[sadc_pkg::SUBCLK_BIT];
    wire runOk   = ~clkStop & ~(subClk & cpuHalt);
    wire step    = clkEn & runOk;

    // ==========================================
    // start and completion events
    // start only on a prescaler tick, which bounds the begin delay
    wire presTick   = (presc == sadc_pkg::PRESC_LAST);
    wire beginConv  = step & startBit & presTick;
    wire startSetWr = (modeWr | setWr) & wStart;
    // a completion raced by a fresh start request is stale and discarded
    // gated by step: a completion pulse held through a halt counts once
    wire doneEv     = step & coreDone & ~startBit & ~startSetWr;
    wire restartEv  = beginConv & coreBusy;

    // ==========================================
    // mode register next values
    logic       next_startBit;
    logic       next_doneFlag;
    logic [2:0] next_chanSel;

    always_comb begin
        next_chanSel  = chanSel;
        next_startBit = startBit;
        next_doneFlag = doneFlag;
        if (beginConv) begin
            next_startBit = 1'b0;
        end
        if (modeWr) begin
            next_chanSel  = pwdata[sadc_pkg::CHAN_MSB:sadc_pkg::CHAN_LSB];
            next_startBit = wStart;
            next_doneFlag = wDone;
        end
        if (setWr & wStart) begin
            next_startBit = 1'b1;
        end
        if (setWr & wDone) begin
            next_doneFlag = 1'b1;
        end
        if (clrWr & wStart) begin
            next_startBit = 1'b0;
        end
        if (clrWr & wDone) begin
            next_doneFlag = 1'b0;
        end
        if (startSetWr) begin
            next_doneFlag = 1'b0;
        end
        if (doneEv) begin
            next_doneFlag = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            chanSel  <= sadc_pkg::MODE_RST[sadc_pkg::CHAN_MSB:sadc_pkg::CHAN_LSB];
            startBit <= sadc_pkg::MODE_RST[sadc_pkg::START_BIT];
            doneFlag <= sadc_pkg::MODE_RST[sadc_pkg::DONE_BIT];
        end else if (clkEn) begin
            chanSel  <= next_chanSel;
            startBit <= next_startBit;
            doneFlag <= next_doneFlag;
        end
    end

    // ==========================================
    // result, clock control, input latch
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            result         <= sadc_pkg::RESULT_RST;
            clkCtl         <= sadc_pkg::CLKCTL_RST;
            analogInputSel <= 3'h0;
        end else if (clkEn) begin
            if (doneEv) begin
                result <= coreResult;
            end
            if (wrAcc & hitClk) begin
                clkCtl <= pwdata[3:0];
            end
            if (beginConv) begin
                analogInputSel <= chanSel;
            end
        end
    end

    // ==========================================
    // prescaler and comparator synchroniser
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            presc   <= 4'h0;
            cmpMeta <= 1'b0;
            cmpSync <= 1'b0;
        end else if (clkEn) begin
            cmpMeta <= cmpAbove;
            cmpSync <= cmpMeta;
            if (runOk) begin
                presc <= presc + 4'h1;
            end
        end
    end

    // ==========================================
    // interrupt status, write one to clear, set wins
    wire [1:0] irqEv  = {restartEv, doneEv};
    wire [1:0] irqClr = (wrAcc & hitStat) ? pwdata[1:0] : 2'b00;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irqStat <= 2'b00;
            irqMask <= sadc_pkg::IRQ_MASK_RST;
            irq     <= 1'b0;
        end else if (clkEn) begin
            irqStat <= (irqStat & ~irqClr) | irqEv;
            if (wrAcc & hitMask) begin
                irqMask <= pwdata[1:0];
            end
            irq <= |(irqStat & irqMask);
        end
    end

    // ==========================================
    // apb answer: ready in the first access cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clkEn) begin
            pready  <= setupPh;
            pslverr <= setupPh & ~addrHit;
            prdata  <= (setupPh & ~pwrite) ? {24'h000000, readByte} : 32'h0000_0000;
        end
    end

    // ==========================================
    // approximation core
    sadc_sar_core #(
        .W       (sadc_pkg::ADC_BITS),
        .SAMPLES (sadc_pkg::SAMPLE_CYC),
        .BITSLOT (sadc_pkg::BIT_CYC)
    ) u_core (
        .clock      (clock),
        .nrst       (nrst),
        .step       (step),
        .begin_i    (beginConv),
        .cmpAbove   (cmpSync),
        .busy       (coreBusy),
        .sampleHold (coreHold),
        .dacCode    (coreDac),
        .result     (coreResult),
        .donePulse  (coreDone)
    );

    assign sampleHold = coreHold;
    assign dacCode    = coreDac;

    // ==========================================
    // checking helpers
    logic [7:0] waitCnt;
    logic [8:0] convCnt;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            waitCnt <= 8'h00;
            convCnt <= 9'h000;
        end else begin
            if (!startBit) begin
                waitCnt <= 8'h00;
            end else if (step & ~beginConv) begin
                waitCnt <= waitCnt + 8'h01;
            end
            if (beginConv) begin
                convCnt <= 9'h000;
            end else if (step & coreBusy) begin
                convCnt <= convCnt + 9'h001;
            end
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_chan_field_write: assert property (modeWr |=>
        chanSel == $past(pwdata[6:4])) else $error("channel field not written");
    a_start_self_clear: assert property (beginConv && !startSetWr |=>
        !startBit) else $error("start bit not cleared at begin");
    a_result_load: assert property (doneEv |=>
        doneFlag && result == $past(coreResult)) else $error("result not loaded");
    a_done_set_op: assert property (setWr && wDone && !startSetWr |=>
        doneFlag) else $error("done bit set op lost");
    a_begin_delay: assert property (waitCnt <= 8'(sadc_pkg::START_WAIT_CYC))
        else $error("conversion start late");
    a_done_cleared: assert property (clkEn && startSetWr && !doneEv |=>
        !doneFlag ##1 !doneFlag) else $error("done flag not cleared by start");
    a_conv_length: assert property (coreDone |->
        convCnt == 9'(sadc_pkg::CONV_CYC)) else $error("conversion length wrong");
    a_result_readonly: assert property (wrAcc && hitResult && !doneEv |=>
        $stable(result)) else $error("result changed by write");
    a_input_held: assert property (coreBusy && !beginConv |=>
        $stable(analogInputSel)) else $error("input changed mid conversion");
    a_halt_freeze: assert property (!runOk |=>
        $stable(dacCode) && $stable(presc)) else $error("converter ran while halted");
    a_restart_done: assert property (restartEv |=>
        !doneFlag) else $error("done set after restart");

    c_conversion: cover property (beginConv ##[1:200] doneEv);
    c_restart: cover property (restartEv);
    c_halt_busy: cover property (coreBusy && !runOk);
    c_irq: cover property (irq);
endmodule
`default_nettype wire

// [tb/sadc_analog_src.sv]
// behavioural analog sources on eight channels behind a sample-and-hold
`timescale 1ns/1ns
`default_nettype none
module sadc_analog_src (
    // clock
    input  wire logic        clock,
    // input levels, channel n in bits 8n+7..8n
    input  wire logic [63:0] levels,
    // converter side
    input  wire logic [2:0]  analogInputSel,
    input  wire logic        sampleHold,
    input  wire logic [7:0]  dacCode,
    output var  logic        cmpAbove
);
    // ==========================================
    // hold capacitor
    logic [7:0] held;

    initial held = 8'h00;
    // the hold follows the selected input only while the converter samples
    always @(posedge clock) begin
        if (sampleHold) begin
            held <= levels[{analogInputSel, 3'b000} +: 8];
        end
    end

    // ==========================================
    // ideal comparator, no offset; the design synchronises it
    assign cmpAbove = (held >= dacCode);
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ==========================================
    // signals
    logic        clock;
    logic        nrst;
    logic        clkEn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cpuHalt;
    logic        cmpAbove;
    logic [2:0]  analogInputSel;
    logic        sampleHold;
    logic [7:0]  dacCode;
    logic        irq;
    logic [63:0] levels;
    logic [31:0] seed;
    logic [31:0] rd;
    logic        lastErr;
    int          n_mismatch;
    int          comparisons;
    int          cyc;

    sadc_sequencer dut (
        .clock(clock), .nrst(nrst), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpuHalt(cpuHalt), .cmpAbove(cmpAbove), .analogInputSel(analogInputSel),
        .sampleHold(sampleHold), .dacCode(dacCode), .irq(irq)
    );

    sadc_analog_src src (
        .clock(clock), .levels(levels), .analogInputSel(analogInputSel),
        .sampleHold(sampleHold), .dacCode(dacCode), .cmpAbove(cmpAbove)
    );

    always #(sadc_pkg::CLK_PERIOD_NS / 2) clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // ideal binary search, msb decided first
    function automatic logic [7:0] expect_code(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            if (v >= (r | (8'h01 << b))) r = r | (8'h01 << b);
        end
        return r;
    endfunction

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout();
        n_mismatch++;
        $display("wrong value at %0t: wait ran out", $time);
        stop_test();
    endtask

    // one apb transfer; entered just after a rising edge, leaves one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // ready and read data are taken at the rising edge that ends the access
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout();
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic wait_for(input bit onIrq, input int limit);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((onIrq ? irq : sampleHold) !== 1'b1 && n < limit);
        if ((onIrq ? irq : sampleHold) !== 1'b1) timeout();
        @(posedge clock);
    endtask

    // kind: 0 enable held low, 1 main clock stopped, 2 halted on subsystem clock, 3 restart
    task automatic conv(input logic [2:0] ch, input int kind);
        int t0;
        logic [7:0] exp;
        apb(1'b1, sadc_pkg::MODE_OFS, {25'h0, ch, 4'h8});
        t0 = cyc;
        wait_for(1'b0, 40);
        check({31'h0, (cyc - t0) <= sadc_pkg::START_WAIT_CYC}, 32'h1);
        check({29'h0, analogInputSel}, {29'h0, ch});
        exp = expect_code(levels[{ch, 3'b000} +: 8]);
        rdchk(sadc_pkg::MODE_OFS, {25'h0, ch, 4'h0});
        if (kind == 3) begin
            levels <= {rnd(), rnd()};
            repeat (30) @(posedge clock);
            exp = expect_code(levels[{ch, 3'b000} +: 8]);
            apb(1'b1, sadc_pkg::MODE_OFS, {25'h0, ch, 4'h8});
            t0 = cyc;
            wait_for(1'b0, 40);
        end
        // the hold has closed by now, so moving the inputs must not matter
        repeat (10) @(posedge clock);
        levels <= {rnd(), rnd()};
        check({24'h0, dacCode}, 32'h80);
        if (kind == 0) begin
            // a low enable must freeze the search in its first slot
            clkEn <= 1'b0;
            repeat (40) @(posedge clock);
            check({24'h0, dacCode}, 32'h80);
            clkEn <= 1'b1;
            t0 = t0 + 40;
        end
        if (kind == 1 || kind == 2) begin
            apb(1'b1, sadc_pkg::CLKCTL_OFS, 32'(kind));
            cpuHalt <= (kind == 2);
            repeat (300) @(posedge clock);
            rdchk(sadc_pkg::MODE_OFS, {25'h0, ch, 4'h0});
            apb(1'b1, sadc_pkg::CLKCTL_OFS, 32'h0);
            cpuHalt <= 1'b0;
        end
        wait_for(1'b1, 400);
        if (kind == 0 || kind == 3) begin
            check({31'h0, (cyc - t0) >= 170 && (cyc - t0) <= 188}, 32'h1);
        end
        rdchk(sadc_pkg::MODE_OFS, {25'h0, ch, 4'h4});
        rdchk(sadc_pkg::RESULT_OFS, {24'h0, exp});
        rdchk(sadc_pkg::IRQ_STAT_OFS, (kind == 3) ? 32'h3 : 32'h1);
        apb(1'b1, sadc_pkg::IRQ_STAT_OFS, 32'h3);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
    endtask

    // ==========================================
    // main sequence
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        clkEn = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cpuHalt = 1'b0;
        levels = 64'h0;
        seed = 32'habf4ba70;
        n_mismatch = 0;
        comparisons = 0;
        cyc = 0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rdchk(sadc_pkg::MODE_OFS, 32'h04);
        rdchk(sadc_pkg::RESULT_OFS, 32'h7F);
        rdchk(sadc_pkg::IRQ_MASK_OFS, 32'h0);
        apb(1'b1, sadc_pkg::RESULT_OFS, 32'hAA);
        rdchk(sadc_pkg::RESULT_OFS, 32'h7F);
        rdchk(8'h1C, 32'h0);
        check({31'h0, lastErr}, 32'h1);
        apb(1'b1, sadc_pkg::MODE_CLR_OFS, 32'h4);
        rdchk(sadc_pkg::MODE_OFS, 32'h0);
        apb(1'b1, sadc_pkg::MODE_SET_OFS, 32'h4);
        rdchk(sadc_pkg::MODE_OFS, 32'h04);
        // start through the set register while the interrupt is masked
        levels <= {rnd(), rnd()};
        apb(1'b1, sadc_pkg::MODE_SET_OFS, 32'h8);
        repeat (220) @(posedge clock);
        rdchk(sadc_pkg::MODE_OFS, 32'h04);
        check({31'h0, irq}, 32'h0);
        rdchk(sadc_pkg::IRQ_STAT_OFS, 32'h1);
        rdchk(sadc_pkg::RESULT_OFS, {24'h0, expect_code(levels[7:0])});
        apb(1'b1, sadc_pkg::IRQ_MASK_OFS, 32'h1);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, sadc_pkg::IRQ_STAT_OFS, 32'h1);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        // all channels in turn, then random ones; extremes come first
        for (int i = 0; i < 12; i++) begin
            if (i == 0) levels <= 64'h0;
            else if (i == 1) levels <= {8{8'hFF}};
            else levels <= {rnd(), rnd()};
            @(posedge clock);
            conv((i < 8) ? 3'(i) : 3'(rnd()), i % 4);
        end
        stop_test();
    end
endmodule
`default_nettype wire
